// ### src/cepsel_pkg.sv
// Purpose: shared constants and types of the card emulation protocol selector
// Assumes: command bytes arrive already deframed from the serial command port
// Notes: register offsets are byte addresses on a 32-bit Avalon-MM slave
`default_nettype none

package cepsel_pkg;

    // ------------------------------------------------------------
    // command stream constants
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_PROTO_SEL = 8'h02;
    localparam logic [7:0] LEN_EMU = 8'h02;
    localparam logic [7:0] CODE_EMU_A = 8'h12;
    localparam logic [7:0] CODE_EMU_B = 8'h13;
    localparam logic [7:0] CODE_EMU_F = 8'h14;

    // parameter byte field positions
    localparam int TX_LO = 6;
    localparam int RX_LO = 4;
    localparam int WAIT_BIT = 3;
    localparam int CLK_BIT = 1;
    localparam int CRC_BIT = 0;

    // result codes
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_BAD_LEN = 8'h81;
    localparam logic [7:0] RES_BAD_PROTO = 8'h82;
    localparam logic [7:0] RES_BAD_RATE = 8'h83;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CFG = 5'h00;
    localparam logic [4:0] REG_CTRL = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h08;
    localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
    localparam logic [4:0] REG_IRQ_MASK = 5'h10;
    localparam int CTRL_LISTEN = 0;
    localparam int CTRL_STOP = 1;
    localparam int IRQ_W = 5;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_NOFIELD = 2;
    localparam int IRQ_FIELD = 3;
    localparam int IRQ_RATE = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {EMU_NONE, EMU_A, EMU_B, EMU_F} cepsel_proto_t;
    typedef enum logic [2:0] {CS_IDLE, CS_LEN, CS_PROTO, CS_PARAM, CS_SKIP} cepsel_cmd_st_t;
    typedef enum logic [1:0] {LS_OFF, LS_WAIT, LS_ACTIVE} cepsel_lst_t;

    typedef struct packed {
        cepsel_proto_t proto;
        logic [1:0] tx_rate;
        logic [1:0] rx_rate;
        logic wait_field;
        logic clk_rec;
        logic crc_auto;
    } cepsel_cfg_t;

    localparam cepsel_cfg_t CFG_RST = '0;

endpackage : cepsel_pkg

`default_nettype wire

// ### src/cepsel_top.sv
// Purpose: decode the emulation protocol select command and hold the emulation setup
// Assumes: one byte per cmd_valid_i pulse; listen and query come as one-cycle pulses
// Notes: registers reached over Avalon-MM; every access waits exactly one cycle
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`default_nettype none

module cepsel_top
    import cepsel_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [7:0] cmd_byte_i,
    input wire logic cmd_valid_i,
    input wire logic listen_i,
    input wire logic field_present_i,
    input wire logic [1:0] rate_det_i,
    input wire logic rate_det_valid_i,
    input wire logic subcarrier_receive_query_i,
    output logic result_valid_o,
    output logic [7:0] result_code_o,
    output cepsel_cfg_t emu_cfg_o,
    output logic listening_o,
    output logic [1:0] rate_report_o,
    output logic rate_report_valid_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    // check a code and parameter byte, giving the result code
    function automatic logic [7:0] param_check(input logic [7:0] code, input logic [7:0] prm);
        logic [7:0] r;
        r = RES_OK;
        if (code != CODE_EMU_A && code != CODE_EMU_B && code != CODE_EMU_F)
            r = RES_BAD_PROTO;
        else if (code == CODE_EMU_A && (prm[TX_LO+1] || prm[RX_LO+1]))
            r = RES_BAD_RATE;
        return r;
    endfunction : param_check

    // build the emulation setup; reserved bits are simply not looked at
    function automatic cepsel_cfg_t cfg_from(input logic [7:0] code, input logic [7:0] prm);
        cepsel_cfg_t c;
        c = CFG_RST;
        c.proto = (code == CODE_EMU_A) ? EMU_A : (code == CODE_EMU_B) ? EMU_B : EMU_F;
        if (code != CODE_EMU_F)
        begin
            c.tx_rate = prm[TX_LO+:2];
            c.rx_rate = prm[RX_LO+:2];
        end
        c.wait_field = prm[WAIT_BIT];
        c.clk_rec = prm[CLK_BIT];
        c.crc_auto = (code != CODE_EMU_A) && prm[CRC_BIT];
        return c;
    endfunction : cfg_from

    // ------------------------------------------------------------
    // command decoder
    // ------------------------------------------------------------
    cepsel_cmd_st_t cst_q;
    cepsel_cfg_t cfg_q;
    logic is_sel_q;
    logic [7:0] code_q;
    logic [7:0] skip_q;
    logic res_valid_q;
    logic [7:0] res_code_q;

    // walk the four byte selection, skip the bodies of other commands
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cst_q <= CS_IDLE;
            cfg_q <= CFG_RST;
            is_sel_q <= 1'b0;
            code_q <= 8'h00;
            skip_q <= 8'h00;
            res_valid_q <= 1'b0;
            res_code_q <= RES_OK;
        end
        else
        begin
            res_valid_q <= 1'b0;
            if (cmd_valid_i)
            begin
                case (cst_q)
                    CS_IDLE:
                    begin
                        is_sel_q <= (cmd_byte_i == OPC_PROTO_SEL);
                        cst_q <= CS_LEN;
                    end
                    CS_LEN:
                    begin
                        skip_q <= cmd_byte_i;
                        if (is_sel_q && cmd_byte_i == LEN_EMU)
                            cst_q <= CS_PROTO;
                        else
                        begin
                            // wrong length: refuse now, then stay aligned with the stream
                            res_valid_q <= is_sel_q;
                            res_code_q <= is_sel_q ? RES_BAD_LEN : res_code_q;
                            cst_q <= (cmd_byte_i == 8'h00) ? CS_IDLE : CS_SKIP;
                        end
                    end
                    CS_SKIP:
                    begin
                        skip_q <= skip_q - 8'h01;
                        if (skip_q == 8'h01)
                            cst_q <= CS_IDLE;
                    end
                    CS_PROTO:
                    begin
                        code_q <= cmd_byte_i;
                        cst_q <= CS_PARAM;
                    end
                    CS_PARAM:
                    begin
                        // refuse reserved rates and unknown codes
                        res_valid_q <= 1'b1;
                        res_code_q <= param_check(code_q, cmd_byte_i);
                        // store the standard picked by the code
                        if (param_check(code_q, cmd_byte_i) == RES_OK)
                            cfg_q <= cfg_from(code_q, cmd_byte_i);
                        cst_q <= CS_IDLE;
                    end
                    default:
                        cst_q <= CS_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic ack_q;
    logic acc;
    logic done;
    logic [31:0] rd_q;
    logic [31:0] rd_mux;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [4:0] reg_addr;
    logic ctl_wr;
    cepsel_lst_t lst_q;
    logic [1:0] det_rate_q;

    // one wait cycle per access: data is latched then presented
    assign acc = avs_read_i | avs_write_i;
    assign done = acc & ack_q;
    assign avs_waitrequest_o = acc & ~ack_q;
    assign avs_readdata_o = rd_q;
    assign reg_addr = {avs_address_i[4:2], 2'b00};
    assign ctl_wr = done & avs_write_i & avs_byteenable_i[0] & (reg_addr == REG_CTRL);

    // read mux; unmapped words read as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            REG_CFG: rd_mux[8:0] = cfg_q;
            REG_STAT: rd_mux[11:0] = {det_rate_q, lst_q, res_code_q};
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // handshake and read data capture
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= acc & ~ack_q;
            if (avs_read_i & ~ack_q)
                rd_q <= rd_mux;
        end
    end

    // mask register
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_mask_q <= IRQ_MASK_RST;
        else if (done & avs_write_i & avs_byteenable_i[0] & (reg_addr == REG_IRQ_MASK))
            irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
    end

    // ------------------------------------------------------------
    // listen and field handling
    // ------------------------------------------------------------
    logic listen_go;
    logic stop_go;
    cepsel_lst_t lst_d;
    logic ev_nofield;
    logic ev_field;
    logic ev_rate;

    assign listen_go = listen_i | (ctl_wr & avs_writedata_i[CTRL_LISTEN]);
    assign stop_go = ctl_wr & avs_writedata_i[CTRL_STOP];

    // field choice takes effect when a listen starts and again when an active field is lost
    // no field gives an error or a wait, as chosen
    always_comb
    begin
        lst_d = lst_q;
        ev_nofield = 1'b0;
        ev_field = 1'b0;
        case (lst_q)
            LS_OFF:
                if (listen_go)
                begin
                    if (cfg_q.proto != EMU_NONE && field_present_i)
                    begin
                        lst_d = LS_ACTIVE;
                        ev_field = 1'b1;
                    end
                    else if (cfg_q.proto != EMU_NONE && cfg_q.wait_field)
                        lst_d = LS_WAIT;
                    else
                        ev_nofield = 1'b1;
                end
            LS_WAIT:
                if (stop_go)
                    lst_d = LS_OFF;
                else if (field_present_i)
                begin
                    lst_d = LS_ACTIVE;
                    ev_field = 1'b1;
                end
            LS_ACTIVE:
                if (stop_go)
                    lst_d = LS_OFF;
                else if (!field_present_i)
                begin
                    // field lost: fall back the same way a listen would
                    lst_d = cfg_q.wait_field ? LS_WAIT : LS_OFF;
                    ev_nofield = !cfg_q.wait_field;
                end
            default:
                lst_d = LS_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            lst_q <= LS_OFF;
        else
            lst_q <= lst_d;
    end

    // ------------------------------------------------------------
    // rate detection and report
    // ------------------------------------------------------------
    // catch detected rate in 18092 mode, answer the query
    assign ev_rate = (cfg_q.proto == EMU_F) && (lst_q == LS_ACTIVE) && rate_det_valid_i;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            det_rate_q <= 2'h0;
            rate_report_o <= 2'h0;
            rate_report_valid_o <= 1'b0;
        end
        else
        begin
            if (ev_rate)
                det_rate_q <= rate_det_i;
            rate_report_valid_o <= subcarrier_receive_query_i;
            // types A and B report the programmed receive rate instead
            if (subcarrier_receive_query_i)
                rate_report_o <= (cfg_q.proto == EMU_F) ? det_rate_q : cfg_q.rx_rate;
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // clear only what the read returned, so a bit set meanwhile survives
    assign irq_clr = (done & avs_read_i & (reg_addr == REG_IRQ_STAT)) ? rd_q[IRQ_W-1:0] : '0;

    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_DONE] = res_valid_q && (res_code_q == RES_OK);
        irq_set[IRQ_ERR] = res_valid_q && (res_code_q != RES_OK);
        irq_set[IRQ_NOFIELD] = ev_nofield;
        irq_set[IRQ_FIELD] = ev_field;
        irq_set[IRQ_RATE] = ev_rate;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_stat_q <= '0;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);
    assign result_valid_o = res_valid_q;
    assign result_code_o = res_code_q;
    assign emu_cfg_o = cfg_q;
    assign listening_o = (lst_q == LS_ACTIVE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sel_seq_a: assert property (
        cst_q == CS_IDLE && cmd_valid_i && cmd_byte_i == OPC_PROTO_SEL
        ##1 cmd_valid_i && cmd_byte_i == LEN_EMU ##1 cmd_valid_i && cmd_byte_i == CODE_EMU_B
        ##1 cmd_valid_i |=> result_valid_o && result_code_o == RES_OK)
        else $error("selection sequence not answered ok");
    proto_map_a: assert property (
        cst_q == CS_PARAM && cmd_valid_i && code_q == CODE_EMU_F && !cmd_byte_i[CRC_BIT]
        |=> emu_cfg_o.proto == EMU_F && !emu_cfg_o.crc_auto)
        else $error("code 0x14 did not select 18092 emulation");
    ratea_rsv_a: assert property (
        cst_q == CS_PARAM && cmd_valid_i && code_q == CODE_EMU_A && cmd_byte_i[TX_LO+1]
        |=> result_code_o == RES_BAD_RATE && $stable(emu_cfg_o))
        else $error("reserved type A rate accepted");
    rateb_a: assert property (
        cst_q == CS_PARAM && cmd_valid_i && code_q == CODE_EMU_B
        |=> emu_cfg_o.tx_rate == $past(cmd_byte_i[7:6])
        && emu_cfg_o.rx_rate == $past(cmd_byte_i[5:4]))
        else $error("type B rates not stored");
    nofield_a: assert property (
        lst_q == LS_OFF && listen_i && !field_present_i && !emu_cfg_o.wait_field
        |=> lst_q == LS_OFF && irq_stat_q[IRQ_NOFIELD])
        else $error("missing field not reported");
    listen_only_a: assert property (
        lst_q == LS_OFF && !listen_i && !(avs_write_i && ack_q) |=> lst_q == LS_OFF)
        else $error("listening started without a listen");
    clk_sel_a: assert property (
        cst_q == CS_PARAM && cmd_valid_i && code_q == CODE_EMU_A
        && !cmd_byte_i[TX_LO+1] && !cmd_byte_i[RX_LO+1]
        |=> emu_cfg_o.clk_rec == $past(cmd_byte_i[CLK_BIT]))
        else $error("clock source bit not applied");
    crc_a_a: assert property (
        emu_cfg_o.proto == EMU_A |-> !emu_cfg_o.crc_auto)
        else $error("crc enabled for type A");
    rate_rpt_a: assert property (
        subcarrier_receive_query_i && emu_cfg_o.proto == EMU_F
        |=> rate_report_valid_o && rate_report_o == $past(det_rate_q))
        else $error("detected rate not reported");
    bad_code_a: assert property (
        cst_q == CS_PARAM && cmd_valid_i && code_q > CODE_EMU_F
        |=> result_valid_o && result_code_o == RES_BAD_PROTO)
        else $error("unknown code not refused");
    bus_wait_a: assert property (
        acc && !avs_waitrequest_o |-> $past(avs_waitrequest_o))
        else $error("access answered without a wait cycle");

    wait_cov_c: cover property (lst_q == LS_WAIT ##[1:20] lst_q == LS_ACTIVE);
    emu_b_cov_c: cover property (result_valid_o && emu_cfg_o.proto == EMU_B);
    irq_cov_c: cover property (irq_o ##[1:20] !irq_o);

endmodule : cepsel_top

`default_nettype wire

// ### tb/cepsel_host_model.sv
// Purpose: host microcontroller model feeding the emulation command stream
// Assumes: every byte is launched just after a rising clock edge
// Notes: reserved parameter bits leave this model as zero for the three known codes; other codes pass the byte unchanged
`default_nettype none

module cepsel_host_model
    import cepsel_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic result_valid_i,
    input wire logic [7:0] result_code_i,
    output logic [7:0] cmd_byte_o,
    output logic cmd_valid_o,
    output logic listen_o,
    output logic query_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------
    // idle lines
    // ------------
    initial
    begin
        cmd_byte_o = 8'h00;
        cmd_valid_o = 1'b0;
        listen_o = 1'b0;
        query_o = 1'b0;
    end

    function automatic logic [7:0] clean(input logic [7:0] c, input logic [7:0] p);
        case (c)
            CODE_EMU_A: return p & 8'hfa;
            CODE_EMU_B: return p & 8'hfb;
            CODE_EMU_F: return p & 8'h0b;
            default: return p;
        endcase
    endfunction : clean

    task automatic select(input logic [7:0] c, input logic [7:0] p, output logic [7:0] res);
        logic [7:0] seq [4];
        int n;
        seq = '{OPC_PROTO_SEL, LEN_EMU, c, clean(c, p)};
        for (int i = 0; i < 4; i++)
        begin
            cmd_byte_o <= seq[i];
            cmd_valid_o <= 1'b1;
            @(posedge sys_clk_i);
        end
        // a released lane must not keep showing the last byte
        cmd_byte_o <= ~seq[3];
        cmd_valid_o <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (result_valid_i !== 1'b1 && n < 8);
        res = (result_valid_i === 1'b1) ? result_code_i : 8'hxx;
        @(posedge sys_clk_i);
    endtask : select

    // short frame of any opcode, no result awaited
    task automatic frame(input logic [7:0] op, input logic [7:0] len, input logic [7:0] body);
        logic [7:0] seq [3];
        seq = '{op, len, body};
        for (int i = 0; i < 3; i++)
        begin
            cmd_byte_o <= seq[i];
            cmd_valid_o <= 1'b1;
            @(posedge sys_clk_i);
        end
        cmd_byte_o <= ~seq[2];
        cmd_valid_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask : frame

    // one-cycle listen or query strobe, then one idle edge
    task automatic pulse(input logic q);
        if (q)
            query_o <= 1'b1;
        else
            listen_o <= 1'b1;
        @(posedge sys_clk_i);
        query_o <= 1'b0;
        listen_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask : pulse

endmodule : cepsel_host_model

`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench of the emulation protocol selector
// Assumes: one clock at 20 MHz, host model drives the command stream
// Notes: expectations are rebuilt from the parameter byte layout
`default_nettype none

module tb
    import cepsel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic nrst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] cmd_byte;
    logic cmd_valid, listen, query, result_valid, listening, rate_report_valid, irq;
    logic field_present = 1'b0;
    logic [1:0] rate_det = 2'h0;
    logic rate_det_valid = 1'b0;
    logic [7:0] result_code;
    logic [1:0] rate_report;
    cepsel_cfg_t emu_cfg;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #25 sys_clk = ~sys_clk;

    cepsel_top dut (.sys_clk_i(sys_clk), .nrst_i(nrst_n), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .cmd_byte_i(cmd_byte), .cmd_valid_i(cmd_valid),
        .listen_i(listen), .field_present_i(field_present), .rate_det_i(rate_det),
        .rate_det_valid_i(rate_det_valid), .subcarrier_receive_query_i(query),
        .result_valid_o(result_valid), .result_code_o(result_code), .emu_cfg_o(emu_cfg),
        .listening_o(listening), .rate_report_o(rate_report),
        .rate_report_valid_o(rate_report_valid), .irq_o(irq));

    cepsel_host_model host (.sys_clk_i(sys_clk), .result_valid_i(result_valid),
        .result_code_i(result_code), .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid),
        .listen_o(listen), .query_o(query));

    // ------------
    // helpers
    // ------------
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // hold the request until waitrequest is seen low at a rising edge
    task automatic av_go(input logic [4:0] a, input logic wr, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        // one wait cycle per access, so the answer lands on the second edge
        chk(n, 32'h2, "bus answer");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : av_go

    task automatic av_wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] x;
        av_go(a, 1'b1, wd, x);
    endtask : av_wr

    function automatic cepsel_cfg_t mk(input cepsel_proto_t p, input logic [1:0] t,
        input logic [1:0] r, input logic w, input logic c, input logic k);
        return {p, t, r, w, c, k};
    endfunction : mk

    // configuration seen both on the port and through the register
    task automatic chk_cfg(input cepsel_cfg_t exp);
        logic [31:0] d;
        chk({23'h0, emu_cfg}, {23'h0, exp}, "cfg port");
        av_go(REG_CFG, 1'b0, 32'h0, d);
        chk(d, {23'h0, exp}, "cfg reg");
    endtask : chk_cfg

    task automatic sel(input logic [7:0] c, input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] r;
        host.select(c, p, r);
        chk({24'h0, r}, {24'h0, exp}, "result");
    endtask : sel

    // ------------
    // scenarios
    // ------------
    task automatic t_reset();
        logic [31:0] d;
        av_go(REG_IRQ_MASK, 1'b0, 32'h0, d);
        chk(d, 32'h0, "mask reset");
        av_go(REG_STAT, 1'b0, 32'h0, d);
        chk(d, 32'h0, "status reset");
        av_wr(5'h14, 32'hff);
        av_go(5'h14, 1'b0, 32'h0, d);
        chk(d, 32'h0, "unmapped");
        chk_cfg(CFG_RST);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_sel_ab();
        logic [31:0] d;
        logic [1:0] t, r;
        sel(CODE_EMU_A, 8'h52, RES_OK);
        chk_cfg(mk(EMU_A, 2'h1, 2'h1, 1'b0, 1'b1, 1'b0));
        av_go(REG_IRQ_STAT, 1'b0, 32'h0, d);
        chk(d, 32'h1, "select irq only");
        for (int i = 0; i < 4; i++)
        begin
            t = i[1:0];
            r = 2'h3 - t;
            sel(CODE_EMU_B, {t, r, t[0], 1'b0, t[1], ~t[0]}, RES_OK);
            chk_cfg(mk(EMU_B, t, r, t[0], t[1], ~t[0]));
        end
        sel(CODE_EMU_F, 8'hfb, RES_OK);
        chk_cfg(mk(EMU_F, 2'h0, 2'h0, 1'b1, 1'b1, 1'b1));
        $display("t_sel_ab done");
    endtask : t_sel_ab

    task automatic t_bad();
        logic [31:0] d;
        sel(CODE_EMU_A, 8'h80, RES_BAD_RATE);
        sel(CODE_EMU_A, 8'h20, RES_BAD_RATE);
        sel(8'h15, 8'h00, RES_BAD_PROTO);
        chk_cfg(mk(EMU_F, 2'h0, 2'h0, 1'b1, 1'b1, 1'b1));
        // wrong length is refused at once and its body skipped
        host.frame(OPC_PROTO_SEL, 8'h01, CODE_EMU_B);
        chk({24'h0, result_code}, {24'h0, RES_BAD_LEN}, "bad length");
        // a foreign body byte must not be taken for a new opcode
        host.frame(8'h03, 8'h01, OPC_PROTO_SEL);
        sel(CODE_EMU_B, 8'h0a, RES_OK);
        chk_cfg(mk(EMU_B, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0));
        av_go(REG_IRQ_STAT, 1'b0, 32'h0, d);
        chk(d, 32'h3, "error irq");
        $display("t_bad done");
    endtask : t_bad

    task automatic t_listen();
        logic [31:0] d;
        sel(CODE_EMU_A, 8'h00, RES_OK);
        av_wr(REG_IRQ_MASK, 32'h4);
        host.pulse(1'b0);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, listening}, 32'h0, "no wait");
        chk({31'h0, irq}, 32'h1, "nofield irq");
        av_go(REG_IRQ_STAT, 1'b0, 32'h0, d);
        chk(d, 32'h5, "nofield stat");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        sel(CODE_EMU_A, 8'h08, RES_OK);
        host.pulse(1'b0);
        repeat (3) @(posedge sys_clk);
        av_go(REG_STAT, 1'b0, 32'h0, d);
        chk({30'h0, d[9:8]}, 32'h1, "waiting");
        field_present <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, listening}, 32'h1, "active");
        av_wr(REG_CTRL, 32'h2);
        av_go(REG_STAT, 1'b0, 32'h0, d);
        chk({30'h0, d[9:8]}, 32'h0, "stopped");
        $display("t_listen done");
    endtask : t_listen

    task automatic t_query();
        logic [31:0] d;
        sel(CODE_EMU_F, 8'h08, RES_OK);
        av_wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, listening}, 32'h1, "f active");
        rate_det <= 2'h2;
        rate_det_valid <= 1'b1;
        @(posedge sys_clk);
        // the detector lane carries nothing valid once the strobe drops
        rate_det <= 2'h1;
        rate_det_valid <= 1'b0;
        @(posedge sys_clk);
        host.pulse(1'b1);
        chk({31'h0, rate_report_valid}, 32'h1, "query answer");
        chk({30'h0, rate_report}, 32'h2, "f rate");
        av_go(REG_STAT, 1'b0, 32'h0, d);
        chk({30'h0, d[11:10]}, 32'h2, "rate stat");
        av_go(REG_IRQ_STAT, 1'b0, 32'h0, d);
        chk(d, 32'h19, "field and rate irq");
        av_wr(REG_CTRL, 32'h2);
        sel(CODE_EMU_A, 8'h10, RES_OK);
        host.pulse(1'b1);
        chk({30'h0, rate_report}, 32'h1, "a rate");
        $display("t_query done");
    endtask : t_query

    // ------------
    // run and watchdog
    // ------------
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        nrst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_sel_ab();
        t_bad();
        t_listen();
        t_query();
        final_report();
    end

endmodule : tb

`default_nettype wire
